/* hdl/gpc_defines.svh */
`ifndef GPC_DEFINES_SVH
`define GPC_DEFINES_SVH

// ==========================================================================
// register indices (byte address = 4 * index)
// ==========================================================================
`define GPC_IDX_GP_STATUS 32'h50003306
`define GPC_IDX_GENERAL_CONTROL 32'h50003308
`define GPC_IDX_SNAPSHOT 32'h5000330A
`define GPC_IDX_IRQ_STATUS 32'h5000330C
`define GPC_IDX_IRQ_MASK 32'h5000330E
`define GPC_ADDR_W 16

// ==========================================================================
// field positions
// ==========================================================================
`define GPC_STATUS_CAL_BIT 0
`define GPC_CTRL_WAKE_REQ_BIT 0
`define GPC_CTRL_WAKE_IRQ_BIT 2
`define GPC_CTRL_PRIO_BIT 4
`define GPC_CTRL_SEL_LSB 5
`define GPC_CTRL_SEL_MSB 6
`define GPC_SNAP_MSB 9
`define GPC_SAMP_MSB 18
`define GPC_EV_WAKE 0
`define GPC_EV_CAPTURE 1
`define GPC_EV_RESTORE 2
`define GPC_EV_W 3

// ==========================================================================
// reset values and answers
// ==========================================================================
`define GPC_RST_CTRL 16'h0000
`define GPC_RST_SNAPSHOT 10'h000
`define GPC_RST_EVENTS 3'h0
`define GPC_RESP_OKAY 2'h0
`define GPC_RESP_SLVERR 2'h2

// ==========================================================================
// timing
// ==========================================================================
`define GPC_CLK_PERIOD_NS 5
`define GPC_LP_PERIOD_NS 31250
`define GPC_LP_DIV (`GPC_LP_PERIOD_NS / `GPC_CLK_PERIOD_NS)
`define GPC_WAKE_TICKS 4

`endif

/* hdl/gpc_lp_divider.sv */
`timescale 1ns/100ps
module gpc_lp_divider #(
  parameter int DIV = 6250
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic lp_tick
);
  typedef struct packed {
    logic [$clog2(DIV)-1:0] cnt;
    logic tick;
  } gpc_div_state_t;

  localparam logic [$clog2(DIV)-1:0] LAST = ($clog2(DIV))'(DIV - 1);

  gpc_div_state_t st;
  gpc_div_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == LAST) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign lp_tick = st.tick;
endmodule : gpc_lp_divider

/* hdl/gpc_pkg.sv */
package gpc_pkg;
  `include "gpc_defines.svh"

  typedef enum logic [1:0] {
    GPC_WAKE_IDLE,
    GPC_WAKE_COUNT,
    GPC_WAKE_FIRE
  } gpc_wake_state_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_held;
    logic w_held;
    logic [`GPC_ADDR_W-3:0] aw_idx;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wake_req;
    logic prio;
    logic [1:0] rd_sel;
    logic [`GPC_SNAP_MSB:0] snapshot;
    logic [`GPC_EV_W-1:0] ev_status;
    logic [`GPC_EV_W-1:0] ev_mask;
    logic irq;
    logic fc_load;
    logic [`GPC_SNAP_MSB:0] fc_value;
    logic wake_irq_seen;
  } gpc_state_t;
endpackage : gpc_pkg

/* hdl/gpc_regs.sv */
`timescale 1ns/100ps
module gpc_regs
  import gpc_pkg::*;
#(
  parameter int LP_DIV = `GPC_LP_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`GPC_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`GPC_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic otp_programmed,
  input wire logic calibration_done,
  input wire logic link_deep_sleep,
  input wire logic link_sleep_entry,
  input wire logic link_wake_sequence,
  input wire logic [9:0] fine_counter,
  input wire logic [9:0] deep_sleep_duration,
  input wire logic [18:0] deep_sleep_time,
  input wire logic deep_sleep_monitor,
  output logic link_wakeup_request,
  output logic link_wakeup_irq,
  output logic bus_priority_select,
  output logic fine_counter_load,
  output logic [9:0] fine_counter_restore,
  output logic irq
);
  import gpc_pkg::*;

  // ========================================================================
  // decode
  // ========================================================================
  localparam int IW = `GPC_ADDR_W - 2;
  localparam logic [31:0] IDX_STATUS = `GPC_IDX_GP_STATUS;
  localparam logic [31:0] IDX_CTRL = `GPC_IDX_GENERAL_CONTROL;
  localparam logic [31:0] IDX_SNAP = `GPC_IDX_SNAPSHOT;
  localparam logic [31:0] IDX_EVST = `GPC_IDX_IRQ_STATUS;
  localparam logic [31:0] IDX_EVMK = `GPC_IDX_IRQ_MASK;

  function automatic logic mapped(input logic [IW-1:0] idx);
    mapped = (idx == IDX_STATUS[IW-1:0]) || (idx == IDX_CTRL[IW-1:0])
          || (idx == IDX_SNAP[IW-1:0]) || (idx == IDX_EVST[IW-1:0])
          || (idx == IDX_EVMK[IW-1:0]);
  endfunction : mapped

  gpc_state_t st;
  gpc_state_t next_st;
  logic lp_tick;
  logic wake_irq;

  // ========================================================================
  // low-power timebase and wake-up delay
  // ========================================================================
  gpc_lp_divider #(
    .DIV(LP_DIV)
  ) u_lp_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .lp_tick(lp_tick)
  );

  gpc_wake_delay #(
    .TICKS(`GPC_WAKE_TICKS)
  ) u_wake (
    .aclk(aclk),
    .aresetn(aresetn),
    .lp_tick(lp_tick),
    .wake_req(st.wake_req),
    .deep_sleep(link_deep_sleep),
    .wake_irq(wake_irq)
  );

  // ========================================================================
  // read data
  // ========================================================================
  logic [15:0] ctrl_word;
  logic [15:0] snap_word;
  logic [31:0] rd_word;
  logic [IW-1:0] ar_idx;

  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[`GPC_CTRL_WAKE_REQ_BIT] = st.wake_req;
    ctrl_word[`GPC_CTRL_WAKE_IRQ_BIT] = wake_irq;
    ctrl_word[`GPC_CTRL_PRIO_BIT] = st.prio;
    ctrl_word[`GPC_CTRL_SEL_MSB:`GPC_CTRL_SEL_LSB] = st.rd_sel;
    snap_word = 16'h0000;
    case (st.rd_sel)
      2'h1: snap_word[9:0] = deep_sleep_duration;
      2'h2: snap_word[9:0] = deep_sleep_time[9:0];
      2'h3: snap_word[9:0] = {deep_sleep_monitor, deep_sleep_time[`GPC_SAMP_MSB:10]};
      default: snap_word[9:0] = st.snapshot;
    endcase
  end

  always_comb begin
    ar_idx = araddr[`GPC_ADDR_W-1:2];
    rd_word = 32'h0000_0000;
    if (ar_idx == IDX_STATUS[IW-1:0]) begin
      rd_word[`GPC_STATUS_CAL_BIT] = otp_programmed && !calibration_done;
    end else if (ar_idx == IDX_CTRL[IW-1:0]) begin
      rd_word[15:0] = ctrl_word;
    end else if (ar_idx == IDX_SNAP[IW-1:0]) begin
      rd_word[15:0] = snap_word;
    end else if (ar_idx == IDX_EVST[IW-1:0]) begin
      rd_word[`GPC_EV_W-1:0] = st.ev_status;
    end else if (ar_idx == IDX_EVMK[IW-1:0]) begin
      rd_word[`GPC_EV_W-1:0] = st.ev_mask;
    end
  end

  // ========================================================================
  // next state
  // ========================================================================
  logic do_write;
  logic [15:0] wr_lo;
  logic [15:0] wr_mask;
  logic [`GPC_EV_W-1:0] events;

  always_comb begin
    next_st = st;
    do_write = 1'b0;
    wr_lo = st.wdata[15:0];
    wr_mask = {{8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
    events = '0;
    next_st.fc_load = 1'b0;

    // write channel capture, either order
    if (awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_idx = awaddr[`GPC_ADDR_W-1:2];
    end
    if (wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata = wdata;
      next_st.wstrb = wstrb;
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      do_write = 1'b1;
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = mapped(st.aw_idx) ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
    end

    if (do_write) begin
      if (st.aw_idx == IDX_CTRL[IW-1:0]) begin
        if (wr_mask[0]) begin
          next_st.wake_req = wr_lo[`GPC_CTRL_WAKE_REQ_BIT];
        end
        if (wr_mask[0]) begin
          next_st.prio = wr_lo[`GPC_CTRL_PRIO_BIT];
          next_st.rd_sel = wr_lo[`GPC_CTRL_SEL_MSB:`GPC_CTRL_SEL_LSB];
        end
      end else if (st.aw_idx == IDX_SNAP[IW-1:0]) begin
        // same effect for every select value; awake writes only park here
        next_st.snapshot = (st.snapshot & ~wr_mask[9:0]) | (wr_lo[9:0] & wr_mask[9:0]);
      end else if (st.aw_idx == IDX_EVST[IW-1:0]) begin
        if (wr_mask[0]) begin
          next_st.ev_status = st.ev_status & ~wr_lo[`GPC_EV_W-1:0];
        end
      end else if (st.aw_idx == IDX_EVMK[IW-1:0]) begin
        if (wr_mask[0]) begin
          next_st.ev_mask = wr_lo[`GPC_EV_W-1:0];
        end
      end
    end

    // hardware capture wins over a software write in the same cycle
    if (link_sleep_entry) begin
      next_st.snapshot = fine_counter;
      events[`GPC_EV_CAPTURE] = 1'b1;
    end
    if (link_wake_sequence) begin
      next_st.fc_load = 1'b1;
      next_st.fc_value = st.snapshot;
      events[`GPC_EV_RESTORE] = 1'b1;
    end
    next_st.wake_irq_seen = wake_irq;
    if (wake_irq && !st.wake_irq_seen) begin
      events[`GPC_EV_WAKE] = 1'b1;
    end
    // set beats clear
    next_st.ev_status = next_st.ev_status | events;
    next_st.irq = |(next_st.ev_status & next_st.ev_mask);

    // read channel
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    if (arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word;
      next_st.rresp = mapped(ar_idx) ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
    end

    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready = !next_st.w_held && !next_st.bvalid;
    next_st.arready = !next_st.rvalid;
  end

  // ========================================================================
  // state register
  // ========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.snapshot <= `GPC_RST_SNAPSHOT;
      st.ev_status <= `GPC_RST_EVENTS;
      st.ev_mask <= `GPC_RST_EVENTS;
    end else begin
      st <= next_st;
    end
  end

  assign awready = st.awready;
  assign wready = st.wready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.arready;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign link_wakeup_request = st.wake_req;
  assign link_wakeup_irq = wake_irq;
  assign bus_priority_select = st.prio;
  assign fine_counter_load = st.fc_load;
  assign fine_counter_restore = st.fc_value;
  assign irq = st.irq;
endmodule : gpc_regs

/* hdl/gpc_wake_delay.sv */
`timescale 1ns/100ps
module gpc_wake_delay
  import gpc_pkg::*;
#(
  parameter int TICKS = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic lp_tick,
  input wire logic wake_req,
  input wire logic deep_sleep,
  output logic wake_irq
);
  typedef struct packed {
    gpc_wake_state_t state;
    logic [2:0] cnt;
    logic irq;
  } gpc_wd_state_t;

  localparam logic [2:0] LAST = 3'(TICKS - 1);

  gpc_wd_state_t st;
  gpc_wd_state_t next_st;

  // request seen mid-period: waiting four ticks lands between 3 and 4 periods
  always_comb begin
    next_st = st;
    case (st.state)
      GPC_WAKE_IDLE: begin
        next_st.cnt = '0;
        if (wake_req && deep_sleep) begin
          next_st.state = GPC_WAKE_COUNT;
        end
      end
      GPC_WAKE_COUNT: begin
        if (lp_tick) begin
          next_st.cnt = st.cnt + 1'b1;
          if (st.cnt == LAST) begin
            next_st.state = GPC_WAKE_FIRE;
            next_st.irq = 1'b1;
          end
        end
      end
      GPC_WAKE_FIRE: begin
        // held until the core has left deep sleep
        if (!deep_sleep) begin
          next_st.state = GPC_WAKE_IDLE;
          next_st.irq = 1'b0;
        end
      end
      default: begin
        next_st.state = GPC_WAKE_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '{state: GPC_WAKE_IDLE, cnt: 3'h0, irq: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign wake_irq = st.irq;
endmodule : gpc_wake_delay

/* testbench/gpc_link_model.sv */
`timescale 1ns/100ps
// ==========================
// link sleep controller: sleeps on command, wakes wake_hold cycles after the irq
module gpc_link_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sleep_cmd,
  input wire logic [4:0] wake_hold,
  input wire logic link_wakeup_irq,
  input wire logic fine_counter_load,
  input wire logic [9:0] fine_counter_restore,
  output logic link_deep_sleep,
  output logic link_sleep_entry,
  output logic link_wake_sequence,
  output logic [9:0] fine_counter
);
  logic [4:0] wait_cnt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_deep_sleep <= 1'h0;
      link_sleep_entry <= 1'h0;
      link_wake_sequence <= 1'h0;
      fine_counter <= 10'h000;
      wait_cnt <= 5'h00;
    end else begin
      link_sleep_entry <= sleep_cmd && !link_deep_sleep;
      link_wake_sequence <= 1'h0;
      wait_cnt <= (link_wakeup_irq && link_deep_sleep) ? wait_cnt + 5'h01 : 5'h00;
      if (fine_counter_load) begin
        fine_counter <= fine_counter_restore;
      end else if (!link_deep_sleep) begin
        fine_counter <= fine_counter + 10'h001;
      end
      if (sleep_cmd && !link_deep_sleep) begin
        link_deep_sleep <= 1'h1;
      end else if (link_deep_sleep && link_wakeup_irq && wait_cnt == wake_hold) begin
        link_deep_sleep <= 1'h0;
        link_wake_sequence <= 1'h1;
      end
    end
  end
endmodule : gpc_link_model

/* testbench/gpc_regs_sva.sv */
`timescale 1ns/100ps
// ==========================
// bus answer and wake timing checks
module gpc_regs_sva #(
  parameter int LP_DIV = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic link_deep_sleep,
  input wire logic link_wakeup_request,
  input wire logic link_wakeup_irq,
  input wire logic link_wake_sequence,
  input wire logic fine_counter_load,
  input wire logic [9:0] fine_counter_restore
);
  // margin of one cycle below and four cycles above for the tick phase and the output register
  localparam int WMIN = 3 * LP_DIV - 1;
  localparam int WMAX = 4 * LP_DIV + 4;
  logic [15:0] wcnt;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  always_ff @(posedge aclk) begin
    if (!aresetn || !link_wakeup_request || !link_deep_sleep) begin
      wcnt <= 16'h0000;
    end else if (wcnt != 16'hFFFF) begin
      wcnt <= wcnt + 16'h0001;
    end
  end

  sequence rd_take;
    arvalid && arready;
  endsequence
  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence

  rd_answer_a: assert property (rd_take |=> rvalid && !arready)
    else $error("read answer missing");
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data moved");
  wr_answer_a: assert property (wr_take |-> ##[1:2] bvalid)
    else $error("write answer missing");
  ready_idle_a: assert property ($rose(aresetn) |-> awready && wready && arready)
    else $error("not ready after reset");
  wake_early_a: assert property ($rose(link_wakeup_irq) |-> wcnt >= WMIN)
    else $error("wake irq too early");
  wake_late_a: assert property ($rose(link_wakeup_request) && link_deep_sleep
    |-> ##[1:WMAX] link_wakeup_irq) else $error("wake irq too late");
  irq_drop_a: assert property ($fell(link_deep_sleep) |-> ##[1:2] !link_wakeup_irq)
    else $error("wake irq stuck");
  fc_load_a: assert property (link_wake_sequence |=> fine_counter_load ##1 !fine_counter_load)
    else $error("restore pulse wrong");
  restore_hold_a: assert property ($changed(fine_counter_restore) |-> fine_counter_load)
    else $error("restore value moved");
endmodule : gpc_regs_sva

bind gpc_regs gpc_regs_sva #(.LP_DIV(LP_DIV)) chk (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready,
  .rvalid, .rready, .rdata, .link_deep_sleep, .link_wakeup_request, .link_wakeup_irq,
  .link_wake_sequence, .fine_counter_load, .fine_counter_restore
);

/* testbench/test_gp_control_sleep_timer_regs.sv */
`timescale 1ns/100ps
`include "gpc_defines.svh"
module test_gp_control_sleep_timer_regs;
  import gpc_pkg::*;
  localparam int LP = 8;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, otp_programmed = 1'h0, calibration_done = 1'h0;
  logic sleep_cmd = 1'h0, deep_sleep_monitor = 1'h0;
  logic [4:0] wake_hold = 5'h1F;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h0, rdata, rdv, v, sv;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, rr;
  logic [9:0] deep_sleep_duration = 10'h000, fine_counter, fine_counter_restore, snap;
  logic [18:0] deep_sleep_time = 19'h00000;
  logic awready, wready, bvalid, arready, rvalid, link_deep_sleep, link_sleep_entry;
  logic link_wake_sequence, link_wakeup_request, link_wakeup_irq, bus_priority_select;
  logic fine_counter_load, irq;
  logic [31:0] regs [5] = '{`GPC_IDX_GP_STATUS, `GPC_IDX_GENERAL_CONTROL,
    `GPC_IDX_SNAPSHOT, `GPC_IDX_IRQ_STATUS, `GPC_IDX_IRQ_MASK};
  int bad_count = 0, cmp_count = 0;

  gpc_regs #(.LP_DIV(LP)) dut (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .otp_programmed, .calibration_done, .link_deep_sleep,
    .link_sleep_entry, .link_wake_sequence, .fine_counter, .deep_sleep_duration,
    .deep_sleep_time, .deep_sleep_monitor, .link_wakeup_request, .link_wakeup_irq,
    .bus_priority_select, .fine_counter_load, .fine_counter_restore, .irq
  );
  gpc_link_model link (
    .aclk, .aresetn, .sleep_cmd, .wake_hold, .link_wakeup_irq, .fine_counter_load,
    .fine_counter_restore, .link_deep_sleep, .link_sleep_entry, .link_wake_sequence,
    .fine_counter
  );

  // ==========================
  // bus master and checking
  function automatic logic [15:0] ad(logic [31:0] idx);
    return {idx[13:0], 2'h0};
  endfunction : ad

  function automatic logic [31:0] snap_exp(logic [1:0] s);
    case (s)
      2'h0: return {22'h0, snap};
      2'h1: return {22'h0, deep_sleep_duration};
      2'h2: return {22'h0, deep_sleep_time[9:0]};
      default: return {22'h0, deep_sleep_monitor, deep_sleep_time[18:10]};
    endcase
  endfunction : snap_exp

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // starts one edge late so a released valid is never raised in the same step
  task automatic wr(input logic [31:0] idx, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= ad(idx);
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [31:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= ad(idx);
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : rd

  task automatic rc(input logic [31:0] idx, input logic [31:0] exp);
    rd(idx, rdv, rr);
    chk(rdv, exp);
    chk(rr, `GPC_RESP_OKAY);
  endtask : rc

  task automatic sleep_wake(input logic [4:0] h, input logic [9:0] nv);
    int n;
    wake_hold <= h;
    sleep_cmd <= 1'h1;
    repeat (2) @(posedge aclk);
    sleep_cmd <= 1'h0;
    rc(`GPC_IDX_SNAPSHOT, {22'h0, fine_counter});
    wr(`GPC_IDX_SNAPSHOT, {22'h0, nv}, rr);
    wr(`GPC_IDX_GENERAL_CONTROL, 32'h1, rr);
    n = 0;
    while (!link_wakeup_irq) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(n >= 3 * LP - 2 && n <= 4 * LP + 2), 32'h1);
    if (h > 5'h8) rc(`GPC_IDX_GENERAL_CONTROL, 32'h5);
    n = 0;
    while (!fine_counter_load && n < 100) begin
      @(posedge aclk);
      n++;
    end
    chk(fine_counter_restore, nv);
    wr(`GPC_IDX_GENERAL_CONTROL, 32'h0, rr);
  endtask : sleep_wake

  task automatic print_verdict();
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  initial begin
    forever #2.5 aclk = ~aclk;
  end

  initial begin
    #(5 * 20000);
    bad_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(15));
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (regs[i]) rc(regs[i], 32'h0);
    rd(32'h50003300, rdv, rr);
    chk(rdv, 32'h0);
    chk(rr, `GPC_RESP_SLVERR);
    wr(32'h50003300, 32'hFFFF, rr);
    chk(rr, `GPC_RESP_SLVERR);
    otp_programmed <= 1'h1;
    rc(`GPC_IDX_GP_STATUS, 32'h1);
    calibration_done <= 1'h1;
    rc(`GPC_IDX_GP_STATUS, 32'h0);
    for (int i = 0; i < 8; i++) begin
      v = ($urandom() & 32'hFFFF_FF9E) | (32'(i % 4) << 5);
      sv = $urandom();
      deep_sleep_duration <= 10'($urandom());
      deep_sleep_time <= 19'($urandom());
      deep_sleep_monitor <= 1'($urandom());
      wr(`GPC_IDX_GENERAL_CONTROL, v, rr);
      rc(`GPC_IDX_GENERAL_CONTROL, v & 32'h71);
      chk(bus_priority_select, v[4]);
      wr(`GPC_IDX_SNAPSHOT, sv, rr);
      snap = sv[9:0];
      rc(`GPC_IDX_SNAPSHOT, snap_exp(v[6:5]));
    end
    wr(`GPC_IDX_GENERAL_CONTROL, 32'h0, rr);
    rc(`GPC_IDX_SNAPSHOT, {22'h0, snap});
    sleep_wake(5'h1F, 10'h3FF);
    // events while masked: all three latched, output quiet
    rc(`GPC_IDX_IRQ_STATUS, 32'h7);
    chk(irq, 1'h0);
    wr(`GPC_IDX_IRQ_MASK, 32'h7, rr);
    repeat (2) @(posedge aclk);
    chk(irq, 1'h1);
    wr(`GPC_IDX_IRQ_STATUS, 32'h2, rr);
    wr(`GPC_IDX_IRQ_MASK, 32'h2, rr);
    repeat (2) @(posedge aclk);
    chk(irq, 1'h0);
    rc(`GPC_IDX_IRQ_STATUS, 32'h5);
    wr(`GPC_IDX_IRQ_STATUS, 32'h5, rr);
    rc(`GPC_IDX_IRQ_STATUS, 32'h0);
    wr(`GPC_IDX_SNAPSHOT, 32'h155, rr);
    chk(fine_counter_restore, 10'h3FF);
    sleep_wake(5'h02, 10'($urandom()));
    print_verdict();
  end
endmodule : test_gp_control_sleep_timer_regs
